// >>> rtl/edge_sync.sv
// Two-flop synchroniser with rising-edge pulse for an outside clock pin.
// Assumes the pin toggles slower than half the system clock rate.
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic async_i,
    output var  logic rise_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
            rise_o <= sync_q & ~prev_q;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/sync_port_vector_playback.sv
// Buffered synchronous output port: loads vectors, plays them on the
// outside vector clock. Assumes commands come from same-clock logic,
// one per cycle while cmd_valid_i is high.
//
// Functional notes
// - Port owns a private buffer of up to 256 vectors loaded before arming.
// - While armed, each rising outside clock edge drives the next stored vector.
// - Port disarms itself after the last loaded vector is driven.
// - Disarm command stops playback at once, buffer not drained.
// - After playback the port holds its last value until changed or reset.
// - Setup with a width empties the buffer, new data from vector 1.
// - Setup without a width keeps the current width mode.
// - Setup without a width appends, never beyond 256 vectors.
// - Bit mode vector sets or clears any of bits 0-7.
// - Byte mode vector is an 8-bit value 0x00 to 0xff.
// - Word mode vector is a 16-bit value 0x0000 to 0xffff.
// - A command names one port 0-11 on a module address 1-12.
// - Buffer kept until re-setup, async write, read, sync on, async port, or reset.
// - Re-arming replays the same stored vectors from the start.
// - Bit mode bits not named keep their previous vector value.
// - Word mode only on even ports; high byte drives the odd companion.
// - A port newly made synchronous starts in byte mode.
`timescale 1ns/10ps
`default_nettype none
module sync_port_vector_playback
    import vec_play_pkg::*;
#(
    parameter logic [3:0] MODULE_ADDR = 4'h1,
    parameter logic [3:0] PORT_ID     = 4'h0,
    parameter int         DEPTH       = BUF_DEPTH
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ext_vector_clock_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [2:0]  cmd_op_i,
    input  wire logic [3:0]  cmd_addr_i,
    input  wire logic [3:0]  cmd_port_i,
    input  wire logic [1:0]  cmd_width_i,
    input  wire logic [15:0] cmd_data_i,
    output var  logic [7:0]  port_o,
    output var  logic [7:0]  companion_o,
    output var  logic        companion_en_o,
    output var  logic        armed_o,
    output var  logic        sync_mode_o,
    output var  logic [8:0]  vec_count_o,
    output var  logic        cmd_err_o
);

    // ****************************************
    // Command decode
    // ****************************************
    op_e         op;
    width_e      wd;
    play_e       state_q;
    width_e      mode_q;
    logic        sync_q;
    logic [8:0]  count_q;
    logic [7:0]  ptr_q;
    logic [15:0] last_q;
    logic        clk_rise;
    logic        range_ok;
    logic        mine;
    logic        idle;
    logic        setup_ok;
    logic        vec_ok;
    logic        arm_ok;
    logic        disarm_ok;
    logic        awr_ok;
    logic        cfg_ok;
    logic        last_vec;
    logic        step;
    logic [15:0] vec_val;

    vec_ram_if #(.AW(PTR_W), .DW(VEC_W)) ram_bus ();

    assign op   = op_e'(cmd_op_i);
    assign wd   = width_e'(cmd_width_i);
    assign idle = (state_q == PB_IDLE);

    assign range_ok = (cmd_addr_i >= MOD_ADDR_MIN) && (cmd_addr_i <= MOD_ADDR_MAX)
                    && (cmd_port_i <= PORT_NUM_MAX);
    assign mine     = cmd_valid_i && range_ok && (cmd_addr_i == MODULE_ADDR)
                    && (cmd_port_i == PORT_ID);

    assign setup_ok  = mine && (op == OP_SETUP) && sync_q && idle
                     && !((wd == W_WORD) && PORT_ID[0]);
    assign vec_ok    = mine && (op == OP_VECTOR) && sync_q && idle
                     && (count_q < BUF_FULL_CNT);
    assign arm_ok    = mine && (op == OP_ARM) && sync_q && idle;
    assign disarm_ok = mine && (op == OP_DISARM);
    // Preset of the port is only legal while not armed
    assign awr_ok    = mine && (op == OP_ASYNC_WR) && idle;
    assign cfg_ok    = mine && idle
                     && ((op == OP_SYNC_ON) || (op == OP_SYNC_OFF) || (op == OP_SET_READ));

    // ****************************************
    // Vector formation
    // ****************************************
    always_comb begin
        vec_val = cmd_data_i;
        unique case (mode_q)
            W_BIT: begin
                vec_val = {8'h00, (last_q[7:0] | cmd_data_i[HI_MASK_LSB +: 8])
                                  & ~cmd_data_i[LO_MASK_LSB +: 8]};
            end
            W_BYTE: begin
                vec_val = {8'h00, cmd_data_i[7:0]};
            end
            W_WORD: begin
                vec_val = cmd_data_i;
            end
            W_NONE: begin
                vec_val = last_q;
            end
        endcase
    end

    assign ram_bus.wr_en   = vec_ok && (mode_q != W_NONE);
    assign ram_bus.wr_addr = count_q[PTR_W-1:0];
    assign ram_bus.wr_data = vec_val;
    assign ram_bus.rd_addr = ptr_q;

    vec_ram #(.DEPTH(DEPTH)) u_ram (
        .mclk_i (mclk_i),
        .bus    (ram_bus.owner)
    );

    edge_sync u_clk (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (ext_vector_clock_i),
        .rise_o    (clk_rise)
    );

    // ****************************************
    // Playback state
    // ****************************************
    assign step     = (state_q == PB_ARMED) && clk_rise;
    assign last_vec = ({1'b0, ptr_q} + 9'h001) >= count_q;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= PB_IDLE;
        end else if (disarm_ok) begin
            state_q <= PB_IDLE;
        end else if (arm_ok && (count_q != 9'h000)) begin
            state_q <= PB_ARMED;
        end else if (step && last_vec) begin
            state_q <= PB_IDLE;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ptr_q <= 8'h00;
        end else if (arm_ok) begin
            ptr_q <= 8'h00;
        end else if (step && !last_vec) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // ****************************************
    // Buffer bookkeeping
    // ****************************************
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_q <= 9'h000;
        end else if (setup_ok && (wd != W_NONE)) begin
            count_q <= 9'h000;
        end else if (awr_ok || cfg_ok) begin
            count_q <= 9'h000;
        end else if (ram_bus.wr_en) begin
            count_q <= count_q + 9'h001;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_q <= W_NONE;
        end else if (cfg_ok) begin
            mode_q <= (op == OP_SYNC_ON) ? W_BYTE : W_NONE;
        end else if (setup_ok && (wd != W_NONE)) begin
            mode_q <= wd;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_q <= 1'b0;
        end else if (cfg_ok) begin
            sync_q <= (op == OP_SYNC_ON);
        end
    end

    // Base for bit-mode changes: last loaded vector, or port value
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_q <= 16'h0000;
        end else if (setup_ok && (wd != W_NONE)) begin
            last_q <= {companion_o, port_o};
        end else if (ram_bus.wr_en) begin
            last_q <= vec_val;
        end
    end

    // ****************************************
    // Port drivers
    // ****************************************
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_o      <= PORT_RST_VAL;
            companion_o <= PORT_RST_VAL;
        end else if (step) begin
            port_o <= ram_bus.rd_data[7:0];
            if (mode_q == W_WORD) begin
                companion_o <= ram_bus.rd_data[15:8];
            end
        end else if (awr_ok) begin
            port_o <= cmd_data_i[7:0];
        end
    end

    // Outputs stay registered; enable is the controller's duty
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            armed_o        <= 1'b0;
            sync_mode_o    <= 1'b0;
            vec_count_o    <= 9'h000;
            companion_en_o <= 1'b0;
            cmd_err_o      <= 1'b0;
        end else begin
            armed_o        <= (state_q == PB_ARMED);
            sync_mode_o    <= sync_q;
            vec_count_o    <= count_q;
            companion_en_o <= (mode_q == W_WORD);
            cmd_err_o      <= cmd_valid_i && !range_ok;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    sequence arm_seq;
        arm_ok && (count_q != 9'h000) && !disarm_ok;
    endsequence

    sequence load_seq;
        setup_ok && (wd != W_NONE) ##1 ram_bus.wr_en;
    endsequence

    arm_rewind_a: assert property (arm_seq |=> (state_q == PB_ARMED) && (ptr_q == 8'h00))
        else $error("arm did not rewind");
    play_step_a: assert property (step |=> port_o == $past(ram_bus.rd_data[7:0]))
        else $error("vector not driven on edge");
    self_stop_a: assert property (step && last_vec && !disarm_ok |=> state_q == PB_IDLE)
        else $error("no disarm after last vector");
    disarm_now_a: assert property (disarm_ok |=> state_q == PB_IDLE)
        else $error("disarm ignored");
    hold_last_a: assert property (idle && !awr_ok |=> $stable(port_o))
        else $error("port changed while idle");
    first_slot_a: assert property (load_seq |-> ram_bus.wr_addr == 8'h00)
        else $error("load not from vector 1");
    keep_mode_a: assert property (setup_ok && (wd == W_NONE) |=> $stable(mode_q))
        else $error("mode changed without width");
    depth_cap_a: assert property (count_q <= BUF_FULL_CNT)
        else $error("buffer overrun");
    bad_range_a: assert property (cmd_valid_i && !range_ok |=> cmd_err_o)
        else $error("bad address not flagged");
    byte_start_a: assert property (cfg_ok && (op == OP_SYNC_ON) |=> mode_q == W_BYTE)
        else $error("new sync port not byte");
    keep_buf_a: assert property (arm_ok |=> $stable(count_q))
        else $error("arm touched buffer");
    odd_word_a: assert property (mode_q == W_WORD |-> !PORT_ID[0])
        else $error("word mode on odd port");
    bit_keep_a: assert property (ram_bus.wr_en && (mode_q == W_BIT)
        |-> ((ram_bus.wr_data[7:0] ^ last_q[7:0])
             & ~(cmd_data_i[15:8] | cmd_data_i[7:0])) == 8'h00)
        else $error("unnamed bit changed");

endmodule
`default_nettype wire

// >>> rtl/vec_play_pkg.sv
// Constants, modes and commands of the vector playback port.
// Assumes a single 25 MHz system clock; no bus, plain command port.
package vec_play_pkg;

    // ****************************************
    // Buffer and addressing
    // ****************************************
    localparam int unsigned BUF_DEPTH     = 256;
    localparam int unsigned PTR_W         = 8;
    localparam int unsigned CNT_W         = 9;
    localparam int unsigned VEC_W         = 16;
    localparam logic [3:0]  MOD_ADDR_MIN  = 4'h1;
    localparam logic [3:0]  MOD_ADDR_MAX  = 4'hc;
    localparam logic [3:0]  PORT_NUM_MAX  = 4'hb;
    localparam logic [7:0]  PORT_RST_VAL  = 8'h00;
    localparam logic [8:0]  BUF_FULL_CNT  = 9'h100;

    // ****************************************
    // Bit mode vector layout
    // ****************************************
    localparam int unsigned HI_MASK_LSB   = 0;
    localparam int unsigned LO_MASK_LSB   = 8;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        W_NONE = 2'h0,
        W_BIT  = 2'h1,
        W_BYTE = 2'h2,
        W_WORD = 2'h3
    } width_e;

    typedef enum logic [2:0] {
        OP_SETUP    = 3'h0,
        OP_VECTOR   = 3'h1,
        OP_ARM      = 3'h2,
        OP_DISARM   = 3'h3,
        OP_ASYNC_WR = 3'h4,
        OP_SYNC_ON  = 3'h5,
        OP_SYNC_OFF = 3'h6,
        OP_SET_READ = 3'h7
    } op_e;

    typedef enum logic {
        PB_IDLE  = 1'b0,
        PB_ARMED = 1'b1
    } play_e;

endpackage

// >>> rtl/vec_ram.sv
// Vector store: one write port, combinational read of the playback entry.
// Assumes the owner never writes and reads the same entry in one cycle.
`timescale 1ns/10ps
`default_nettype none
module vec_ram #(
    parameter int DEPTH = 256
) (
    input  wire logic  mclk_i,
    vec_ram_if.store   bus
);
    logic [$bits(bus.wr_data)-1:0] mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (bus.wr_en) begin
            mem[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Read ahead of the clock edge so the next vector is ready at once
    assign bus.rd_data = mem[bus.rd_addr];
endmodule
`default_nettype wire

// >>> rtl/vec_ram_if.sv
// Write and read path between the playback core and its vector store.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface vec_ram_if #(
    parameter int AW = 8,
    parameter int DW = 16
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
                   input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
                   output rd_data);
endinterface
`default_nettype wire

// >>> tb/test_sync_port_vector_playback.sv
// Self-checking bench for the vector playback port.
// Assumes vclk_source as the outside clock and one port at address 1.
`timescale 1ns/10ps
`default_nettype none
module test_sync_port_vector_playback import vec_play_pkg::*;;
    logic        mclk_i    = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        vclk;
    logic        vbusy;
    logic        go        = 1'b0;
    logic        slow      = 1'b0;
    logic [8:0]  nclk      = 9'h0;
    logic        cmd_valid = 1'b0;
    logic [2:0]  cmd_op    = 3'h0;
    logic [3:0]  cmd_addr  = 4'h1;
    logic [3:0]  cmd_port  = 4'h0;
    logic [1:0]  cmd_width = 2'h0;
    logic [15:0] cmd_data  = 16'h0;
    logic [7:0]  port_o;
    logic [7:0]  companion_o;
    logic        companion_en_o;
    logic        armed_o;
    logic        sync_mode_o;
    logic        cmd_err_o;
    logic [8:0]  vec_count_o;
    logic [15:0] expq[$];
    logic [15:0] seen      = 16'h0;
    logic [15:0] lastv     = 16'h0;
    logic [15:0] v;
    logic [15:0] vec[4];
    logic [15:0] bv[4]     = '{16'h0008, 16'h0802, 16'h00a0, 16'h8200};
    logic [3:0]  ea[6]     = '{4'h0, 4'hd, 4'h1, 4'h2, 4'h1, 4'hc};
    logic [3:0]  ep[6]     = '{4'h0, 4'h0, 4'hc, 4'h0, 4'hf, 4'hb};
    logic [15:0] ee[6]     = '{16'h1, 16'h1, 16'h1, 16'h0, 16'h1, 16'h0};
    int          miscompares = 0;
    int          n_compared  = 0;
    int          k;

    sync_port_vector_playback sync_port_vector_playback_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ext_vector_clock_i(vclk),
        .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr),
        .cmd_port_i(cmd_port), .cmd_width_i(cmd_width), .cmd_data_i(cmd_data),
        .port_o(port_o), .companion_o(companion_o),
        .companion_en_o(companion_en_o), .armed_o(armed_o),
        .sync_mode_o(sync_mode_o), .vec_count_o(vec_count_o),
        .cmd_err_o(cmd_err_o));

    vclk_source vclk_source_i (.go_i(go), .slow_i(slow), .n_i(nclk), .clk_o(vclk),
        .busy_o(vbusy));

    always #20 mclk_i = ~mclk_i;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", what, e, g);
            miscompares++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // Leaves the strobe high so commands may follow back to back
    task automatic cmd(input op_e op, input width_e w, input logic [15:0] d);
        @(posedge mclk_i);
        #1;
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_width = w;
        cmd_data  = d;
    endtask

    task automatic rel();
        @(posedge mclk_i);
        #1;
        cmd_valid = 1'b0;
    endtask

    task automatic push(input logic [15:0] x);
        expq.push_back(x);
        lastv = x;
    endtask

    // Nonzero and unlike its neighbours, so every step shows as a change
    task automatic rnd(input logic [15:0] mx, input logic [15:0] a, input logic [15:0] b);
        do
            v = 16'($urandom_range(mx, 1));
        while (v == a || v == b);
    endtask

    task automatic arm();
        cmd(OP_ARM, W_NONE, 16'h0);
        rel();
        cyc(2);
    endtask

    task automatic play(input int n, input logic s, input logic a);
        nclk = 9'(n);
        slow = s;
        go   = 1'b1;
        cyc(1);
        go = 1'b0;
        k  = 0;
        while (vbusy !== 1'b0 && k < 9000) begin
            cyc(1);
            k++;
        end
        if (k >= 9000) begin
            miscompares++;
            finish_test();
        end
        cyc(5);
        chk("queue left", 16'h0, 16'(expq.size()));
        chk("armed after end", 16'(a), 16'(armed_o));
    endtask

    // ****************************************
    // Drive watcher
    // ****************************************
    // Sampled mid-cycle, well clear of the edge that launches the drive
    always @(negedge mclk_i) begin
        if (!sys_rst_i && {companion_o, port_o} !== seen) begin
            seen = {companion_o, port_o};
            if (expq.size() == 0)
                chk("unexpected drive", ~seen, seen);
            else
                chk("port drive", expq.pop_front(), seen);
        end
    end

    initial begin
        void'($urandom(86));
        cyc(2);
        sys_rst_i = 1'b0;
        cyc(3);
        chk("reset drive", 16'h0, {companion_o, port_o});
        chk("reset flags", 16'h0, 16'({armed_o, sync_mode_o, vec_count_o}));
        for (int i = 0; i < 6; i++) begin
            cmd_addr = ea[i];
            cmd_port = ep[i];
            cmd(OP_DISARM, W_NONE, 16'h0);
            rel();
            k = int'(cmd_err_o === 1'b1);
            repeat (3) begin
                cyc(1);
                k += int'(cmd_err_o === 1'b1);
            end
            chk("error pulses", ee[i], 16'(k));
        end
        cmd_addr = 4'h1;
        cmd_port = 4'h0;
        $display("test address check done");
        cmd(OP_SYNC_ON, W_NONE, 16'h0);
        cmd(OP_SETUP, W_NONE, 16'h0);
        for (int i = 0; i < 3; i++) begin
            // Last vector must differ from the first, as replay follows it
            rnd(16'hff, lastv, (i == 2) ? vec[0] : 16'h0);
            vec[i] = v;
            cmd(OP_VECTOR, W_NONE, v);
            push(v);
        end
        rel();
        cyc(2);
        chk("loaded count", 16'h3, 16'(vec_count_o));
        arm();
        chk("armed", 16'h1, 16'(armed_o));
        play(3, 1'b0, 1'b0);
        $display("test byte playback done");
        rnd(16'hff, lastv, vec[0]);
        vec[3] = v;
        cmd(OP_SETUP, W_NONE, 16'h0);
        cmd(OP_VECTOR, W_NONE, v);
        arm();
        chk("appended count", 16'h4, 16'(vec_count_o));
        for (int i = 0; i < 4; i++)
            push(vec[i]);
        play(4, 1'b1, 1'b0);
        $display("test append replay done");
        push(vec[0]);
        push(vec[1]);
        arm();
        play(2, 1'b0, 1'b1);
        cmd(OP_DISARM, W_NONE, 16'h0);
        rel();
        cyc(2);
        play(2, 1'b0, 1'b0);
        $display("test disarm done");
        cmd(OP_SETUP, W_BYTE, 16'h0);
        rel();
        cyc(2);
        chk("cleared count", 16'h0, 16'(vec_count_o));
        for (int i = 0; i < 256; i++) begin
            rnd(16'hff, lastv, 16'h0);
            cmd(OP_VECTOR, W_NONE, v);
            push(v);
        end
        cmd(OP_VECTOR, W_NONE, 16'h55);
        rel();
        cyc(2);
        chk("full count", 16'(BUF_FULL_CNT), 16'(vec_count_o));
        arm();
        play(256, 1'b1, 1'b0);
        $display("test full buffer done");
        cmd(OP_ASYNC_WR, W_NONE, 16'h0);
        push(16'h0);
        rel();
        cyc(2);
        chk("count after write", 16'h0, 16'(vec_count_o));
        arm();
        chk("empty arm", 16'h0, 16'(armed_o));
        cmd(OP_SETUP, W_BIT, 16'h0);
        for (int i = 0; i < 4; i++) begin
            if (i == 3)
                cmd(OP_SETUP, W_NONE, 16'h0);
            cmd(OP_VECTOR, W_NONE, bv[i]);
            push({8'h0, (lastv[7:0] | bv[i][7:0]) & ~bv[i][15:8]});
        end
        arm();
        play(4, 1'b0, 1'b0);
        $display("test bit mode done");
        cmd(OP_SETUP, W_WORD, 16'h0);
        for (int i = 0; i < 2; i++) begin
            rnd(16'hffff, lastv, 16'h0);
            cmd(OP_VECTOR, W_NONE, v);
            push(v);
        end
        rel();
        cyc(2);
        chk("companion enable", 16'h1, 16'(companion_en_o));
        arm();
        play(2, 1'b0, 1'b0);
        $display("test word mode done");
        cmd(OP_SET_READ, W_NONE, 16'h0);
        rel();
        cyc(2);
        chk("count after read", 16'h0, 16'(vec_count_o));
        cmd(OP_SYNC_ON, W_NONE, 16'h0);
        cmd(OP_SYNC_OFF, W_NONE, 16'h0);
        rel();
        cyc(2);
        chk("sync after off", 16'h0, 16'({sync_mode_o, companion_en_o}));
        $display("test reconfigure done");
        finish_test();
    end
endmodule
`default_nettype wire

// >>> tb/vclk_source.sv
// Model of the outside test set: drives the vector clock in bursts.
// Assumes the bench starts a burst only after the previous one is over.
`timescale 1ns/10ps
`default_nettype none
module vclk_source (
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic [8:0] n_i,
    output var  logic       clk_o,
    output var  logic       busy_o
);
    int half;

    initial begin
        clk_o  = 1'b0;
        busy_o = 1'b0;
    end

    // ****************************************
    // Burst generator
    // ****************************************
    // port enabled beforehand
    // Stands low between bursts; phase unrelated to the system clock
    always @(posedge go_i) begin
        busy_o = 1'b1;
        half   = slow_i ? 320 : 160;
        #37;
        repeat (n_i) begin
            clk_o = 1'b1;
            #(half);
            clk_o = 1'b0;
            #(half);
        end
        busy_o = 1'b0;
    end
endmodule
`default_nettype wire
